// ==== dcl_host.sv ====
// host model: byte-wide register writes and reads into the loader
`timescale 1ns/100ps
module dcl_host (
	// clock
	input  wire logic               clk_i,
	// register port
	output dcl_pkg::dcl_req_s       req_o,
	input  wire logic [7:0]         rdata_i,
	input  wire logic               rvalid_i
);
	import dcl_pkg::*;

	// idle bus from time zero
	initial req_o = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		req_o.wr <= 1'b0;
	endtask

	// one byte per read; no answer leaves x behind
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		req_o.rd <= 1'b0;
		d = 8'hXX;
		repeat (3) begin
			#1;
			if (rvalid_i === 1'b1) d = rdata_i;
			@(posedge clk_i);
		end
	endtask
endmodule // dcl_host

// ==== dcl_loader.sv ====
// device side of code loading, checksum and power sequencing registers
`timescale 1ns/100ps
module dcl_loader (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	// register port, one byte per access
	input  wire dcl_pkg::dcl_req_s  req_i,
	output logic [7:0]              rdata_o,
	output logic                    rvalid_o,
	// program memory write port
	output logic                    prog_we_o,
	output logic [7:0]              prog_addr_o,
	output logic [7:0]              prog_data_o,
	// device control state
	output logic [7:0]              power_1_o,
	output logic [7:0]              power_2_o,
	output logic [7:0]              analog_mute_o,
	output logic                    boot_imem_o,
	output logic                    rom_mode2_o,
	output logic [7:0]              gain_o,
	output logic                    sw_reset_o
);
	import dcl_pkg::*;

	// selection and control registers
	logic [7:0] book_q, book_d;       // selected book
	logic [7:0] page_q, page_d;       // selected page
	logic [7:0] crc_q, crc_d;         // running checksum
	logic [7:0] pwr1_q, pwr1_d;       // dsp and divider power
	logic [7:0] pwr2_q, pwr2_d;       // analog power
	logic [7:0] amute_q, amute_d;     // analog mute
	logic [7:0] dspc_q, dspc_d;       // dsp control
	logic       boot_q, boot_d;       // instruction memory boot
	logic       swr_q, swr_d;         // software reset pulse
	logic [7:0] rd_q, rd_d;           // read data
	logic       rv_q, rv_d;           // read valid
	logic       pwe_q, pwe_d;         // program write strobe
	logic [7:0] pa_q, pa_d;           // program address
	logic [7:0] pd_q, pd_d;           // program data
	logic       ramp_up, ramp_down;   // ramp commands
	logic [7:0] gain;                 // ramp gain
	logic       muted;                // ramp at floor
	logic       clr;                  // software reset clears state
	logic       rom2_q, rom2_d;       // rom mode 2 decoded, registered

	// true when current selection is book b, page p
	function automatic logic sel(input logic [7:0] bk, input logic [7:0] b,
	                             input logic [7:0] pg, input logic [7:0] p);
		return (bk == b) && (pg == p);
	endfunction

	// crc-8 one byte step, msb first
	function automatic logic [7:0] crc8(input logic [7:0] c,
	                                    input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction

	logic in_b0, in_prog, in_dspb, in_stat;
	assign in_b0   = sel(book_q, RST_ZERO, page_q, RST_PAGE);
	assign in_prog = sel(book_q, BOOK_DSP, page_q, PAGE_PROGRAM);
	assign in_dspb = sel(book_q, BOOK_DSP, page_q, RST_PAGE);
	assign in_stat = sel(book_q, BOOK_STATUS, page_q, PAGE_STATUS);
	assign clr     = swr_q;

	// mute control in book 100 drives the soft ramp
	assign ramp_up   = req_i.wr && in_dspb && req_i.addr == ADDR_MUTE &&
	                   req_i.wdata == VAL_UNMUTE;
	assign ramp_down = req_i.wr && in_dspb && req_i.addr == ADDR_MUTE &&
	                   req_i.wdata == VAL_SOFT_MUTE;

	dcl_ramp #(
		.STEP_CYC (RAMP_STEP_CYC)
	) u_ramp (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.up_i      (ramp_up),
		.down_i    (ramp_down),
		.gain_o    (gain),
		.muted_o   (muted)
	);

	// register write, read and checksum next-state
	always_comb begin
		book_d  = book_q;
		page_d  = page_q;
		crc_d   = crc_q;
		pwr1_d  = pwr1_q;
		pwr2_d  = pwr2_q;
		amute_d = amute_q;
		dspc_d  = dspc_q;
		boot_d  = boot_q;
		swr_d   = 1'b0;
		rd_d    = rd_q;
		rv_d    = 1'b0;
		pwe_d   = 1'b0;
		pa_d    = pa_q;
		pd_d    = pd_q;
		if (req_i.wr) begin
			if (req_i.addr == ADDR_BOOK) begin
				book_d = req_i.wdata;
			end else if (req_i.addr == ADDR_PAGE) begin
				page_d = req_i.wdata;
			end else if (in_prog) begin
				pwe_d = 1'b1;
				pa_d  = req_i.addr;
				pd_d  = req_i.wdata;
				crc_d = crc8(crc_q, req_i.wdata);
			end else if (in_dspb && req_i.addr == ADDR_BOOT) begin
				boot_d = (req_i.wdata == VAL_BOOT_IMEM);
			end else if (in_b0 && req_i.addr == ADDR_RESET) begin
				swr_d = (req_i.wdata == VAL_SW_RESET);
			end else if (in_b0 && req_i.addr == ADDR_POWER_1) begin
				pwr1_d = req_i.wdata;
			end else if (in_b0 && req_i.addr == ADDR_POWER_2) begin
				pwr2_d = req_i.wdata;
			end else if (in_b0 && req_i.addr == ADDR_MUTE) begin
				amute_d = req_i.wdata;
			end else if (in_b0 && req_i.addr == ADDR_DSP_CTRL) begin
				dspc_d = req_i.wdata;
			end
		end
		// software reset clears checksum
		// placed after the writes so the clear beats a write in that cycle
		if (clr) begin
			crc_d  = RST_ZERO;
			pwr1_d = RST_ZERO;
			pwr2_d = RST_ZERO;
			amute_d = RST_ZERO;
			dspc_d = RST_DSP_CTRL;
			boot_d = 1'b0;
			pwe_d  = 1'b0;
			pa_d   = RST_ZERO;
		end
		// decode ahead of the flop so the port comes from a register
		rom2_d = (dspc_d == VAL_ROM_MODE2);
		if (req_i.rd) begin
			rv_d = 1'b1;
			rd_d = RST_ZERO;
			if (req_i.addr == ADDR_BOOK) begin
				rd_d = book_q;
			end else if (req_i.addr == ADDR_PAGE) begin
				rd_d = page_q;
			end else if (in_prog) begin
				rd_d = RST_ZERO;
			end else if (in_b0 && req_i.addr == ADDR_CHECKSUM) begin
				rd_d = crc_q;
			end else if (in_b0 && req_i.addr == ADDR_POWER_1) begin
				rd_d = pwr1_q;
			end else if (in_b0 && req_i.addr == ADDR_POWER_2) begin
				rd_d = pwr2_q;
			end else if (in_b0 && req_i.addr == ADDR_MUTE) begin
				rd_d = amute_q;
			end else if (in_b0 && req_i.addr == ADDR_DSP_CTRL) begin
				rd_d = dspc_q;
			end else if (in_stat && req_i.addr == ADDR_STATUS) begin
				rd_d = {7'h00, muted};
			end
		end
	end

	// registers; selection survives software reset
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			book_q  <= RST_ZERO;
			page_q  <= RST_PAGE;
			crc_q   <= RST_ZERO;
			pwr1_q  <= RST_ZERO;
			pwr2_q  <= RST_ZERO;
			amute_q <= RST_ZERO;
			dspc_q  <= RST_DSP_CTRL;
			rom2_q  <= 1'b0;
			boot_q  <= 1'b0;
			swr_q   <= 1'b0;
			rd_q    <= RST_ZERO;
			rv_q    <= 1'b0;
			pwe_q   <= 1'b0;
			pa_q    <= RST_ZERO;
			pd_q    <= RST_ZERO;
		end else begin
			book_q  <= book_d;
			page_q  <= page_d;
			crc_q   <= crc_d;
			pwr1_q  <= pwr1_d;
			pwr2_q  <= pwr2_d;
			amute_q <= amute_d;
			dspc_q  <= dspc_d;
			rom2_q  <= rom2_d;
			boot_q  <= boot_d;
			swr_q   <= swr_d;
			rd_q    <= rd_d;
			rv_q    <= rv_d;
			pwe_q   <= pwe_d;
			pa_q    <= pa_d;
			pd_q    <= pd_d;
		end
	end

	// gain output registered so the port comes from a flop
	logic [7:0] gain_q;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			gain_q <= GAIN_MIN;
		end else begin
			gain_q <= gain;
		end
	end

	assign rdata_o       = rd_q;
	assign rvalid_o      = rv_q;
	assign prog_we_o     = pwe_q;
	assign prog_addr_o   = pa_q;
	assign prog_data_o   = pd_q;
	assign power_1_o     = pwr1_q;
	assign power_2_o     = pwr2_q;
	assign analog_mute_o = amute_q;
	assign boot_imem_o   = boot_q;
	assign rom_mode2_o   = rom2_q;
	assign gain_o        = gain_q;
	assign sw_reset_o    = swr_q;

	// checks
	property p_crc_clear;
		@(posedge clk_i) disable iff (!reset_n_i)
		swr_q |=> (crc_q == RST_ZERO);
	endproperty
	a_crc_clear: assert property (p_crc_clear)
		else $error("checksum not cleared by software reset");

	property p_crc_step;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req_i.wr && in_prog && !clr && req_i.addr != ADDR_BOOK &&
		 req_i.addr != ADDR_PAGE) |=> (crc_q == crc8($past(crc_q),
		 $past(req_i.wdata)));
	endproperty
	a_crc_step: assert property (p_crc_step)
		else $error("checksum did not advance on program write");

	property p_no_readback;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req_i.rd && in_prog && req_i.addr != ADDR_BOOK &&
		 req_i.addr != ADDR_PAGE) |=> (rvalid_o && rdata_o == RST_ZERO);
	endproperty
	a_no_readback: assert property (p_no_readback)
		else $error("program memory readback not refused");

	property p_book_sel;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req_i.wr && req_i.addr == ADDR_BOOK) |=>
		(book_q == $past(req_i.wdata));
	endproperty
	a_book_sel: assert property (p_book_sel)
		else $error("book selection not taken");

	property p_sel_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		!(req_i.wr && (req_i.addr == ADDR_BOOK || req_i.addr == ADDR_PAGE))
		|=> $stable(book_q) && $stable(page_q);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("selection changed without a write");

	property p_rom2;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req_i.wr && in_b0 && req_i.addr == ADDR_DSP_CTRL &&
		 req_i.wdata == VAL_ROM_MODE2 && !clr) |=> rom_mode2_o;
	endproperty
	a_rom2: assert property (p_rom2)
		else $error("rom mode 2 not entered");

	property p_soft_up;
		@(posedge clk_i) disable iff (!reset_n_i)
		(gain_q < GAIN_MAX) |=> (gain_q <= $past(gain_q) + 8'h01);
	endproperty
	a_soft_up: assert property (p_soft_up)
		else $error("unmute gain stepped abruptly");

	property p_soft_down;
		@(posedge clk_i) disable iff (!reset_n_i)
		(gain_q > GAIN_MIN && !ramp_up) |=>
		($past(gain_q) - gain_q) <= 8'h01 || gain_q >= $past(gain_q);
	endproperty
	a_soft_down: assert property (p_soft_down)
		else $error("mute gain stepped abruptly");

endmodule // dcl_loader

// ==== dcl_loader_tb_top.sv ====
// testbench: bring-up, code load, checksum and power sequencing
`timescale 1ns/100ps
module dcl_loader_tb_top;
	import dcl_pkg::*;
	logic       clk     = 1'b0;
	logic       reset_n = 1'b0;
	dcl_req_s   req;
	logic [7:0] rdata, p_addr, p_data, pw1, pw2, amute, gain, r, crc;
	logic       rvalid, p_we, boot, rom2, swr;
	int         errors = 0;
	int         check_count = 0;
	int         cyc = 0;
	int         n;
	// program image, includes an all-ones byte
	logic [7:0] prog [3] = '{8'h3C, 8'hA5, 8'hFF};

	always #2 clk = ~clk;

	dcl_host host_u (.clk_i(clk), .req_o(req), .rdata_i(rdata),
		.rvalid_i(rvalid));

	dcl_loader dut_u (.clk_i(clk), .reset_n_i(reset_n), .req_i(req),
		.rdata_o(rdata), .rvalid_o(rvalid), .prog_we_o(p_we),
		.prog_addr_o(p_addr), .prog_data_o(p_data), .power_1_o(pw1),
		.power_2_o(pw2), .analog_mute_o(amute), .boot_imem_o(boot),
		.rom_mode2_o(rom2), .gain_o(gain), .sw_reset_o(swr));

	// hang guard: two reset waits plus ramps fit well below this
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			errors++;
			$display("BAD %0t timeout", $time);
			give_verdict();
		end
	end

	// compare and count
	task automatic chk(input logic [7:0] s, input logic [7:0] e,
		input string m);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t %s seen %h want %h", $time, m, s, e);
		end
	endtask

	// crc-8, poly 0x07, msb first
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		for (int i = 0; i < 8; i++)
			x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
		return x;
	endfunction

	// software reset from book 0 page 0, then the settle wait
	task automatic sw_reset();
		host_u.wr(ADDR_PAGE, 8'h00);
		host_u.wr(ADDR_BOOK, 8'h00);
		host_u.wr(ADDR_RESET, VAL_SW_RESET);
		#1;
		for (int i = 0; i < 3 && swr !== 1'b1; i++) @(posedge clk) #1;
		chk({7'h00, swr}, 8'h01, "sw reset pulse");
		repeat (25000) @(posedge clk);
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		host_u.rd(ADDR_CHECKSUM, r);
		chk(r, 8'h00, "checksum after reset");
		host_u.rd(ADDR_DSP_CTRL, r);
		chk(r, RST_DSP_CTRL, "dsp ctrl reset");
		chk({7'h00, rom2}, 8'h00, "rom mode off");
		host_u.rd(8'h33, r);
		chk(r, 8'h00, "unmapped read");
		$display("test reset values done");
		sw_reset();
		host_u.wr(ADDR_BOOK, BOOK_DSP);
		host_u.wr(ADDR_BOOT, VAL_BOOT_IMEM);
		#1 chk({7'h00, boot}, 8'h01, "boot request");
		host_u.wr(ADDR_BOOK, 8'h00);
		$display("test boot done");
		host_u.wr(ADDR_BOOK, BOOK_DSP);
		host_u.wr(ADDR_PAGE, PAGE_PROGRAM);
		crc = 8'h00;
		for (n = 0; n < 3; n++) begin
			host_u.wr(8'h10 + n[7:0], prog[n]);
			#1 chk({7'h00, p_we}, 8'h01, "prog strobe");
			chk(p_addr, 8'h10 + n[7:0], "prog addr");
			chk(p_data, prog[n], "prog data");
			crc = crc8(crc, prog[n]);
		end
		host_u.rd(8'h10, r);
		chk(r, 8'h00, "no program readback");
		host_u.wr(ADDR_PAGE, 8'h00);
		host_u.wr(ADDR_BOOK, 8'h00);
		host_u.wr(ADDR_CHECKSUM, 8'h55);
		host_u.rd(ADDR_CHECKSUM, r);
		chk(r, crc, "checksum");
		$display("test code load done");
		sw_reset();
		host_u.rd(ADDR_CHECKSUM, r);
		chk(r, 8'h00, "checksum cleared");
		host_u.wr(ADDR_DSP_CTRL, VAL_ROM_MODE2);
		#1 chk({7'h00, rom2}, 8'h01, "rom mode 2");
		host_u.wr(ADDR_POWER_2, 8'hA3);
		#1 chk(pw2, 8'hA3, "analog on");
		host_u.wr(ADDR_POWER_1, 8'hB8);
		#1 chk(pw1, 8'hB8, "dsp on");
		host_u.wr(ADDR_MUTE, VAL_UNMUTE);
		#1 chk(amute, 8'h00, "analog unmute");
		host_u.wr(ADDR_BOOK, BOOK_DSP);
		host_u.wr(ADDR_MUTE, VAL_UNMUTE);
		for (n = 0; n < 1300 && gain !== GAIN_MAX; n++) @(posedge clk) #1;
		chk(gain, GAIN_MAX, "gain up");
		chk({7'h00, n >= 63 * RAMP_STEP_CYC}, 8'h01, "ramp soft");
		$display("test power up done");
		host_u.wr(8'h30, 8'h5A);
		#1 chk(gain, GAIN_MAX, "gain held over coeff write");
		host_u.wr(ADDR_MUTE, VAL_SOFT_MUTE);
		host_u.wr(ADDR_BOOK, BOOK_STATUS);
		host_u.wr(ADDR_PAGE, PAGE_STATUS);
		host_u.rd(ADDR_STATUS, r);
		chk({7'h00, r[0]}, 8'h00, "mute busy");
		for (n = 0; n < 400 && r[0] !== 1'b1; n++)
			host_u.rd(ADDR_STATUS, r);
		chk({7'h00, r[0]}, 8'h01, "mute done");
		chk(gain, GAIN_MIN, "gain down");
		host_u.wr(ADDR_PAGE, 8'h00);
		host_u.wr(ADDR_BOOK, 8'h00);
		host_u.wr(ADDR_MUTE, 8'h03);
		#1 chk(amute, 8'h03, "analog mute");
		host_u.wr(ADDR_POWER_1, 8'h20);
		#1 chk(pw1, 8'h20, "dsp off");
		host_u.wr(ADDR_POWER_2, 8'h00);
		#1 chk(pw2, 8'h00, "analog off");
		host_u.wr(ADDR_PAGE, 8'h00);
		host_u.wr(ADDR_POWER_1, 8'h00);
		#1 chk(pw1, 8'h00, "divider off");
		$display("test power down done");
		give_verdict();
	end
endmodule // dcl_loader_tb_top

// ==== dcl_pkg.sv ====
// package: register map, field values and timing constants for the loader
package dcl_pkg;

	// byte-wide register bus
	localparam int DATA_W = 8;

	// book 0 page 0 register addresses
	localparam logic [7:0] ADDR_PAGE     = 8'h00;
	localparam logic [7:0] ADDR_RESET    = 8'h01;
	localparam logic [7:0] ADDR_POWER_1  = 8'h04;
	localparam logic [7:0] ADDR_POWER_2  = 8'h05;
	localparam logic [7:0] ADDR_MUTE     = 8'h07;
	localparam logic [7:0] ADDR_CHECKSUM = 8'h20;
	localparam logic [7:0] ADDR_DSP_CTRL = 8'h22;
	localparam logic [7:0] ADDR_BOOK     = 8'h7F;

	// book 100 registers
	localparam logic [7:0] BOOK_DSP      = 8'h64;
	localparam logic [7:0] ADDR_BOOT     = 8'h46;
	localparam logic [7:0] PAGE_PROGRAM  = 8'h01;

	// status flag location: book 120, page 15, register 122
	localparam logic [7:0] BOOK_STATUS   = 8'h78;
	localparam logic [7:0] PAGE_STATUS   = 8'h0F;
	localparam logic [7:0] ADDR_STATUS   = 8'h7A;

	// written values
	localparam logic [7:0] VAL_SW_RESET  = 8'h01;
	localparam logic [7:0] VAL_BOOT_IMEM = 8'h01;
	localparam logic [7:0] VAL_ROM_MODE2 = 8'h22;
	localparam logic [7:0] VAL_UNMUTE    = 8'h00;
	localparam logic [7:0] VAL_SOFT_MUTE = 8'h01;

	// reset values
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_DSP_CTRL  = 8'h01;
	localparam logic [7:0] RST_PAGE      = 8'h00;

	// crc-8 polynomial x^8+x^2+x+1
	localparam logic [7:0] CRC_POLY      = 8'h07;

	// soft ramp: gain steps and cycles per step
	localparam int         RAMP_STEPS    = 64;
	localparam int         RAMP_STEP_CYC = 16;

	// soft volume gain range
	localparam logic [7:0] GAIN_MAX      = 8'h40;
	localparam logic [7:0] GAIN_MIN      = 8'h00;

	// ramp direction
	typedef enum logic [1:0] {
		RAMP_IDLE,
		RAMP_UP,
		RAMP_DOWN
	} dcl_ramp_e;

	// one register bus transaction
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dcl_req_s;

endpackage : dcl_pkg

// ==== dcl_ramp.sv ====
// soft gain ramp used for stepped mute and unmute
`timescale 1ns/100ps
module dcl_ramp #(
	parameter int STEP_CYC = dcl_pkg::RAMP_STEP_CYC
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	// control
	input  wire logic               up_i,
	input  wire logic               down_i,
	// status
	output logic [7:0]              gain_o,
	output logic                    muted_o
);
	import dcl_pkg::*;

	localparam int CW = $clog2(STEP_CYC + 1);

	dcl_ramp_e   dir_q, dir_d;   // ramp direction
	logic [7:0]  gain_q, gain_d; // present gain
	logic [CW-1:0] cnt_q, cnt_d; // step divider
	logic        step;           // one-cycle step enable

	// divider gives one step enable every STEP_CYC cycles
	assign step = (cnt_q == CW'(STEP_CYC - 1));

	// next-state: a new command turns the ramp round at once
	always_comb begin
		dir_d  = dir_q;
		gain_d = gain_q;
		cnt_d  = step ? '0 : cnt_q + CW'(1);
		if (up_i) begin
			dir_d = RAMP_UP;
		end else if (down_i) begin
			dir_d = RAMP_DOWN;
		end
		case (dir_q)
			RAMP_UP: begin
				if (step && gain_q < GAIN_MAX) gain_d = gain_q + 8'h01;
			end
			RAMP_DOWN: begin
				if (step && gain_q > GAIN_MIN) gain_d = gain_q - 8'h01;
			end
			default: begin
				gain_d = gain_q;
			end
		endcase
	end

	// registers
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			dir_q  <= RAMP_IDLE;
			gain_q <= GAIN_MIN;
			cnt_q  <= '0;
		end else begin
			dir_q  <= dir_d;
			gain_q <= gain_d;
			cnt_q  <= cnt_d;
		end
	end

	assign gain_o  = gain_q;
	assign muted_o = (gain_q == GAIN_MIN);

endmodule // dcl_ramp
